//--- cluster_buffer_mem.sv
`timescale 1ns/1ps
`default_nettype none
module cluster_buffer_mem (
  // clock and reset
  input  wire logic                                 clk,
  input  wire logic                                 rst,
  // write side
  input  wire logic                                 we,
  input  wire logic [dma_prio_pkg::CLUSTER_AW-1:0]  waddr,
  input  wire logic [dma_prio_pkg::DATA_W-1:0]      wdata,
  // read side
  input  wire logic [dma_prio_pkg::CLUSTER_AW-1:0]  raddr,
  output var  logic [dma_prio_pkg::DATA_W-1:0]      rdata
);
  // eight words, index 0 through 7
  logic [dma_prio_pkg::DATA_W-1:0] mem [dma_prio_pkg::CLUSTER_DEPTH];
  logic [dma_prio_pkg::DATA_W-1:0] rdata_reg;
  logic [dma_prio_pkg::DATA_W-1:0] rdata_next;

  // read is old data on a same-address write; the cycle saved matters more than bypass
  always_comb begin
    rdata_next = mem[raddr];
  end

  // storage has no reset, only the read register does
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (rst) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;

  // a written word comes back on a later read of that index
  a_cluster_word_kept: assert property (@(posedge clk) disable iff (rst)
    we ##1 (raddr == $past(waddr) && !we) |=> rdata == $past(wdata, 2))
    else $error("cluster word not read back");
endmodule
`default_nettype wire

//--- dma_prio_pkg.sv
`default_nettype none
package dma_prio_pkg;
  // channel counts of the two controllers
  localparam int INT_CHANNELS = 4;
  localparam int EXT_CHANNELS = 2;
  // cluster buffer shape
  localparam int CLUSTER_DEPTH = 8;
  localparam int CLUSTER_AW    = 3;
  localparam int DATA_W        = 32;
  // shared address offset
  localparam int          OFFSET_W     = 32;
  localparam logic [31:0] OFFSET_RESET = 32'h0000_0000;
  // timer select codes for the external-bus controller
  localparam logic SEL_TIMER_ONE   = 1'b0;
  localparam logic SEL_TIMER_SEVEN = 1'b1;
  // channel index codes
  localparam logic [1:0] CH0 = 2'h0;
  localparam logic [1:0] CH1 = 2'h1;
  localparam logic [1:0] CH2 = 2'h2;
  localparam logic [1:0] CH3 = 2'h3;
  // arbiter states
  typedef enum logic {
    ARB_IDLE = 1'b0,
    ARB_BUSY = 1'b1
  } arb_state_t;
endpackage
`default_nettype wire

//--- dma_priority_activation.sv
`timescale 1ns/1ps
`default_nettype none
module dma_priority_activation (
  // clock and reset
  input  wire logic                                 CLK,
  input  wire logic                                 RST,
  // internal controller requests and enables
  input  wire logic [3:0]                           INT_SW_START,
  input  wire logic [3:0]                           INT_PERIPH_EVENT,
  input  wire logic [3:0]                           INT_ENABLE,
  // internal controller grant
  input  wire logic                                 INT_UNIT_DONE,
  output var  logic                                 INT_GRANT_VALID,
  output var  logic [1:0]                           INT_GRANT_CH,
  // external-bus controller requests and enables
  input  wire logic [1:0]                           EXT_SW_START,
  input  wire logic [1:0]                           EXT_REQ_PIN,
  input  wire logic [1:0]                           EXT_TIMER_SEL,
  input  wire logic                                 TIMER_ONE_MATCH_A,
  input  wire logic                                 TIMER_SEVEN_MATCH_A,
  input  wire logic [1:0]                           EXT_ENABLE,
  // external-bus controller grant
  input  wire logic                                 EXT_UNIT_DONE,
  output var  logic                                 EXT_GRANT_VALID,
  output var  logic                                 EXT_GRANT_CH,
  // shared address offset
  input  wire logic                                 OFFSET_LOAD,
  input  wire logic [dma_prio_pkg::OFFSET_W-1:0]    OFFSET_DATA,
  output var  logic [dma_prio_pkg::OFFSET_W-1:0]    OFFSET_VALUE,
  // cluster buffer
  input  wire logic                                 CLUSTER_WE,
  input  wire logic [dma_prio_pkg::CLUSTER_AW-1:0]  CLUSTER_WADDR,
  input  wire logic [dma_prio_pkg::DATA_W-1:0]      CLUSTER_WDATA,
  input  wire logic [dma_prio_pkg::CLUSTER_AW-1:0]  CLUSTER_RADDR,
  output var  logic [dma_prio_pkg::DATA_W-1:0]      CLUSTER_RDATA
);

  // fixed priority pick: lowest index wins, {valid, index}
  function automatic logic [2:0] prio_pick(input logic [3:0] req);
    logic [2:0] res;
    res = 3'h0;
    if (req[0]) begin
      res = {1'b1, dma_prio_pkg::CH0};
    end else if (req[1]) begin
      res = {1'b1, dma_prio_pkg::CH1};
    end else if (req[2]) begin
      res = {1'b1, dma_prio_pkg::CH2};
    end else if (req[3]) begin
      res = {1'b1, dma_prio_pkg::CH3};
    end
    return res;
  endfunction

  // internal controller state
  dma_prio_pkg::arb_state_t int_state_reg;   // idle or serving a unit
  dma_prio_pkg::arb_state_t int_state_next;
  logic [3:0]               int_pend_reg;    // sticky start requests
  logic [3:0]               int_pend_next;
  logic [1:0]               int_ch_reg;      // channel being served
  logic [1:0]               int_ch_next;
  logic [3:0]               int_req_en;      // pending and enabled
  logic [2:0]               int_pick;        // {valid, index}
  logic [3:0]               int_clr;         // bit taken by a grant

  // external controller state
  dma_prio_pkg::arb_state_t ext_state_reg;
  dma_prio_pkg::arb_state_t ext_state_next;
  logic [1:0]               ext_pend_reg;
  logic [1:0]               ext_pend_next;
  logic                     ext_ch_reg;
  logic                     ext_ch_next;
  logic [1:0]               ext_req_en;
  logic [2:0]               ext_pick;
  logic [1:0]               ext_clr;
  logic [1:0]               ext_set;         // all start sources merged
  logic [1:0]               timer_hit;       // selected compare-match A

  // request pin synchroniser and edge detect
  logic [1:0] pin_meta_reg;   // first stage, read only by the second
  logic [1:0] pin_sync_reg;
  logic [1:0] pin_prev_reg;
  logic [1:0] pin_edge;

  // shared offset
  logic [dma_prio_pkg::OFFSET_W-1:0] offset_reg;
  logic [dma_prio_pkg::OFFSET_W-1:0] offset_next;

  // internal arbiter next state
  always_comb begin
    int_req_en     = int_pend_reg & INT_ENABLE;
    int_pick       = prio_pick(int_req_en);
    int_clr        = 4'h0;
    int_state_next = int_state_reg;
    int_ch_next    = int_ch_reg;
    unique case (int_state_reg)
      dma_prio_pkg::ARB_IDLE: begin
        if (int_pick[2]) begin
          int_state_next = dma_prio_pkg::ARB_BUSY;
          int_ch_next    = int_pick[1:0];
          int_clr        = 4'h1 << int_pick[1:0];
        end
      end
      dma_prio_pkg::ARB_BUSY: begin
        // on unit end the next winner is chosen at once, no idle gap
        if (INT_UNIT_DONE) begin
          if (int_pick[2]) begin
            int_ch_next = int_pick[1:0];
            int_clr     = 4'h1 << int_pick[1:0];
          end else begin
            int_state_next = dma_prio_pkg::ARB_IDLE;
          end
        end
      end
    endcase
    // software write or selected peripheral event; a new set beats the grant clear
    // the event wiring assumes the interrupt controller was given the vector
    int_pend_next = (int_pend_reg & ~int_clr) | INT_SW_START | INT_PERIPH_EVENT;
  end

  // external arbiter next state
  always_comb begin
    for (int i = 0; i < dma_prio_pkg::EXT_CHANNELS; i++) begin
      timer_hit[i] = (EXT_TIMER_SEL[i] == dma_prio_pkg::SEL_TIMER_SEVEN) ?
                     TIMER_SEVEN_MATCH_A : TIMER_ONE_MATCH_A;
    end
    pin_edge       = pin_sync_reg & ~pin_prev_reg;
    ext_set        = EXT_SW_START | pin_edge | timer_hit;
    ext_req_en     = ext_pend_reg & EXT_ENABLE;
    ext_pick       = prio_pick({2'b00, ext_req_en});
    ext_clr        = 2'h0;
    ext_state_next = ext_state_reg;
    ext_ch_next    = ext_ch_reg;
    unique case (ext_state_reg)
      dma_prio_pkg::ARB_IDLE: begin
        if (ext_pick[2]) begin
          ext_state_next = dma_prio_pkg::ARB_BUSY;
          ext_ch_next    = ext_pick[0];
          ext_clr        = 2'h1 << ext_pick[0];
        end
      end
      dma_prio_pkg::ARB_BUSY: begin
        if (EXT_UNIT_DONE) begin
          if (ext_pick[2]) begin
            ext_ch_next = ext_pick[0];
            ext_clr     = 2'h1 << ext_pick[0];
          end else begin
            ext_state_next = dma_prio_pkg::ARB_IDLE;
          end
        end
      end
    endcase
    ext_pend_next = (ext_pend_reg & ~ext_clr) | ext_set;
  end

  // offset next value; only one copy exists for the whole module
  always_comb begin
    offset_next = OFFSET_LOAD ? OFFSET_DATA : offset_reg;
  end

  // register all state except the cluster buffer, which holds its own
  always_ff @(posedge CLK) begin
    if (RST) begin
      int_state_reg <= dma_prio_pkg::ARB_IDLE;
      int_pend_reg  <= 4'h0;
      int_ch_reg    <= dma_prio_pkg::CH0;
      ext_state_reg <= dma_prio_pkg::ARB_IDLE;
      ext_pend_reg  <= 2'h0;
      ext_ch_reg    <= 1'b0;
      pin_meta_reg  <= 2'h0;
      pin_sync_reg  <= 2'h0;
      pin_prev_reg  <= 2'h0;
      offset_reg    <= dma_prio_pkg::OFFSET_RESET;
    end else begin
      int_state_reg <= int_state_next;
      int_pend_reg  <= int_pend_next;
      int_ch_reg    <= int_ch_next;
      ext_state_reg <= ext_state_next;
      ext_pend_reg  <= ext_pend_next;
      ext_ch_reg    <= ext_ch_next;
      pin_meta_reg  <= EXT_REQ_PIN;
      pin_sync_reg  <= pin_meta_reg;
      pin_prev_reg  <= pin_sync_reg;
      offset_reg    <= offset_next;
    end
  end

  // outputs straight from flops
  assign INT_GRANT_VALID = (int_state_reg == dma_prio_pkg::ARB_BUSY);
  assign INT_GRANT_CH    = int_ch_reg;
  assign EXT_GRANT_VALID = (ext_state_reg == dma_prio_pkg::ARB_BUSY);
  assign EXT_GRANT_CH    = ext_ch_reg;
  assign OFFSET_VALUE    = offset_reg;

  // cluster buffer words
  cluster_buffer_mem u_cluster (
    .clk   (CLK),
    .rst   (RST),
    .we    (CLUSTER_WE),
    .waddr (CLUSTER_WADDR),
    .wdata (CLUSTER_WDATA),
    .raddr (CLUSTER_RADDR),
    .rdata (CLUSTER_RDATA)
  );

  a_int_ch0_first: assert property (@(posedge CLK) disable iff (RST)
    !INT_GRANT_VALID && int_req_en[0] |=> INT_GRANT_VALID && INT_GRANT_CH == 2'h0)
    else $error("internal channel 0 not served first");

  a_int_ch3_last: assert property (@(posedge CLK) disable iff (RST)
    !INT_GRANT_VALID && int_req_en == 4'h8 |=> INT_GRANT_CH == 2'h3)
    else $error("internal channel 3 alone not served");

  a_int_order_mid: assert property (@(posedge CLK) disable iff (RST)
    INT_UNIT_DONE && INT_GRANT_VALID && int_req_en[1:0] == 2'b10
    |=> INT_GRANT_VALID && INT_GRANT_CH == 2'h1)
    else $error("internal re-arbitration skipped channel 1");

  a_ext_ch0_first: assert property (@(posedge CLK) disable iff (RST)
    (!EXT_GRANT_VALID || EXT_UNIT_DONE) && ext_req_en == 2'b11 |=> EXT_GRANT_CH == 1'b0)
    else $error("external channel 1 beat channel 0");

  a_sw_start_int: assert property (@(posedge CLK) disable iff (RST)
    INT_SW_START[3] |=> int_pend_reg[3])
    else $error("software start lost");

  a_pin_start_ext: assert property (@(posedge CLK) disable iff (RST)
    $rose(EXT_REQ_PIN[1]) ##3 1'b1 |-> ext_pend_reg[1] || EXT_GRANT_VALID)
    else $error("request pin start lost");

  a_periph_start: assert property (@(posedge CLK) disable iff (RST)
    INT_PERIPH_EVENT[2] |=> int_pend_reg[2])
    else $error("peripheral event start lost");

  a_timer_only: assert property (@(posedge CLK) disable iff (RST)
    !ext_pend_reg[0] && !ext_set[0] |=> !ext_pend_reg[0])
    else $error("external channel started with no source");

  // a selected timer match must reach the channel that listens to it
  a_timer_seven_start: assert property (@(posedge CLK) disable iff (RST)
    TIMER_SEVEN_MATCH_A && EXT_TIMER_SEL[0] == dma_prio_pkg::SEL_TIMER_SEVEN |=> ext_pend_reg[0])
    else $error("selected timer match did not start channel");

  a_unit_held: assert property (@(posedge CLK) disable iff (RST)
    INT_GRANT_VALID && !INT_UNIT_DONE |=> INT_GRANT_VALID && $stable(INT_GRANT_CH))
    else $error("grant changed before unit end");

  a_offset_shared: assert property (@(posedge CLK) disable iff (RST)
    OFFSET_LOAD ##1 !OFFSET_LOAD [*2] |-> OFFSET_VALUE == $past(OFFSET_DATA, 2))
    else $error("shared offset not kept");
endmodule
`default_nettype wire

//--- dma_priority_activation_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dma_priority_activation_tb;
  // stimulus and observed signals
  logic        clk, rst;
  logic [3:0]  int_sw, int_en, pe;
  logic        int_done, ext_done, igv, egv, egc, t1, t7, off_ld, clu_we;
  logic [1:0]  ext_sw, ext_sel, ext_en, pin, igc;
  logic [31:0] off_d, off_v, clu_wd, clu_rd;
  logic [2:0]  clu_wa, clu_ra;
  // bookkeeping; the ceiling is far above the roughly 60 cycles used
  int          n_fail = 0;
  int          num_checks = 0;
  int          cyc = 0;
  localparam int LIMIT = 3000;

  requester_model p (.clk(clk), .periph_event(pe), .req_pin(pin),
    .tmr_one_a(t1), .tmr_seven_a(t7));

  dma_priority_activation dut (.CLK(clk), .RST(rst), .INT_SW_START(int_sw),
    .INT_PERIPH_EVENT(pe), .INT_ENABLE(int_en), .INT_UNIT_DONE(int_done),
    .INT_GRANT_VALID(igv), .INT_GRANT_CH(igc), .EXT_SW_START(ext_sw),
    .EXT_REQ_PIN(pin), .EXT_TIMER_SEL(ext_sel), .TIMER_ONE_MATCH_A(t1),
    .TIMER_SEVEN_MATCH_A(t7), .EXT_ENABLE(ext_en), .EXT_UNIT_DONE(ext_done),
    .EXT_GRANT_VALID(egv), .EXT_GRANT_CH(egc), .OFFSET_LOAD(off_ld),
    .OFFSET_DATA(off_d), .OFFSET_VALUE(off_v), .CLUSTER_WE(clu_we),
    .CLUSTER_WADDR(clu_wa), .CLUSTER_WDATA(clu_wd), .CLUSTER_RADDR(clu_ra),
    .CLUSTER_RDATA(clu_rd));

  // free-running system clock, 8 ns
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // advance n edges, then 1 ns so driven inputs never race the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // single comparison point
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // close the run
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // one-cycle unit-finished pulse, internal or external side
  task automatic unit_done(input logic ext);
    int_done = ~ext;
    ext_done = ext;
    step(1);
    int_done = 1'b0;
    ext_done = 1'b0;
  endtask

  // shared offset: resets to zero, loads, then holds
  task automatic t_offset();
    check(off_v, dma_prio_pkg::OFFSET_RESET);
    off_d  = 32'h1234_5678;
    off_ld = 1'b1;
    step(1);
    off_ld = 1'b0;
    check(off_v, 32'h1234_5678);
    step(3);
    check(off_v, 32'h1234_5678);
    $display("test offset done");
  endtask

  // all eight buffer words hold distinct data
  task automatic t_cluster();
    clu_we = 1'b1;
    for (int i = 0; i < 8; i++) begin
      clu_wa = 3'(i);
      clu_wd = 32'ha5a5_0000 | 32'(i);
      step(1);
    end
    clu_we = 1'b0;
    for (int i = 0; i < 8; i++) begin
      clu_ra = 3'(7 - i);
      step(1);
      check(clu_rd, 32'ha5a5_0000 | 32'(7 - i));
    end
    $display("test cluster done");
  endtask

  // four simultaneous software starts drain in fixed order
  task automatic t_int_prio();
    int_en = 4'hf;
    int_sw = 4'hf;
    step(1);
    int_sw = 4'h0;
    step(1);
    check(32'({igv, igc}), 32'h4);
    for (int c = 1; c < 4; c++) begin
      unit_done(1'b0);
      check(32'({igv, igc}), 32'(4 + c));
    end
    unit_done(1'b0);
    check(32'(igv), 32'h0);
    $display("test int_prio done");
  endtask

  // disabled channel stays pending and is served once enabled
  task automatic t_int_enable();
    int_en = 4'hb;
    p.fire_periph(4'hc);
    step(1);
    check(32'({igv, igc}), 32'h7);
    int_en = 4'hf;
    unit_done(1'b0);
    check(32'({igv, igc}), 32'h6);
    unit_done(1'b0);
    check(32'(igv), 32'h0);
    $display("test int_enable done");
  endtask

  // bus controller: software, timer and pin activation
  task automatic t_ext();
    ext_en = 2'h3;
    ext_sw = 2'h3;
    step(1);
    ext_sw = 2'h0;
    step(1);
    check(32'({egv, egc}), 32'h2);
    unit_done(1'b1);
    check(32'({egv, egc}), 32'h3);
    unit_done(1'b1);
    check(32'(egv), 32'h0);
    // channel 0 listens to timer seven, channel 1 to timer one
    ext_sel = 2'b01;
    p.fire_timer(dma_prio_pkg::SEL_TIMER_ONE);
    step(1);
    check(32'({egv, egc}), 32'h3);
    unit_done(1'b1);
    p.fire_timer(dma_prio_pkg::SEL_TIMER_SEVEN);
    step(1);
    check(32'({egv, egc}), 32'h2);
    unit_done(1'b1);
    // pin edge passes a two-stage synchronizer before pending
    p.set_pin(2'h2);
    step(3);
    check(32'(egv), 32'h0);
    step(1);
    check(32'({egv, egc}), 32'h3);
    check(32'(igv), 32'h0);
    p.set_pin(2'h0);
    unit_done(1'b1);
    check(32'(egv), 32'h0);
    $display("test ext done");
  endtask

  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_fail++;
      give_verdict();
    end
  end

  // main sequence
  initial begin
    rst = 1'b1;
    {int_sw, int_en, int_done, ext_done, off_ld, clu_we} = '0;
    {ext_sw, ext_sel, ext_en, off_d, clu_wd, clu_wa, clu_ra} = '0;
    step(16);
    rst = 1'b0;
    step(1);
    t_offset();
    t_cluster();
    t_int_prio();
    t_int_enable();
    t_ext();
    give_verdict();
  end
endmodule
`default_nettype wire

//--- requester_model.sv
`timescale 1ns/1ps
`default_nettype none
module requester_model (
  // clock
  input  wire logic       clk,
  // activation lines toward the block
  output var  logic [3:0] periph_event,
  output var  logic [1:0] req_pin,
  output var  logic       tmr_one_a,
  output var  logic       tmr_seven_a
);
  // all lines quiet until a scenario asks for an event
  initial begin
    periph_event = 4'h0;
    req_pin      = 2'h0;
    tmr_one_a    = 1'b0;
    tmr_seven_a  = 1'b0;
  end
  // interrupt controller has routed the selected vector to these channels
  task automatic fire_periph(input logic [3:0] mask);
    periph_event = mask;
    @(posedge clk);
    #1 periph_event = 4'h0;
  endtask
  // one-cycle compare-match A from one of the two timers
  task automatic fire_timer(input logic seven);
    tmr_one_a   = ~seven;
    tmr_seven_a = seven;
    @(posedge clk);
    #1 tmr_one_a = 1'b0;
    tmr_seven_a = 1'b0;
  endtask
  // pin is a level driven by the device; only bus channels listen to it
  task automatic set_pin(input logic [1:0] lvl);
    req_pin = lvl;
  endtask
endmodule
`default_nettype wire
